// ---- hdl/lrd_cfg.svh ----
// constants of the display RAM command decoder: offsets, fields, counts
`ifndef LRD_CFG_SVH
`define LRD_CFG_SVH

// register byte offsets on the AHB-Lite slave
`define LRD_OFS_XFER      8'h00
`define LRD_OFS_STATUS    8'h04
`define LRD_OFS_RAM_ROW0  8'h10
`define LRD_OFS_RAM_ROW1  8'h14
`define LRD_OFS_RAM_ROW2  8'h18
`define LRD_OFS_RAM_ROW3  8'h1C

// transfer register fields
`define LRD_XFER_START_BIT 8

// status register fields
`define LRD_ST_PTR_LSB     0
`define LRD_ST_SUB_LSB     8
`define LRD_ST_MODE_LSB    12
`define LRD_ST_EN_BIT      16
`define LRD_ST_INB_BIT     17
`define LRD_ST_OUTB_BIT    18
`define LRD_ST_ALTB_BIT    19
`define LRD_ST_RATE_LSB    20
`define LRD_ST_BIAS_BIT    22
`define LRD_ST_DATA_BIT    24
`define LRD_ST_PHASE_BIT   25
`define LRD_ST_STRAP_LSB   28

// drive mode codes of the configure command
`define LRD_MODE_STATIC   2'h1
`define LRD_MODE_MUX2     2'h2
`define LRD_MODE_MUX3     2'h3
`define LRD_MODE_MUX4     2'h0

// data pointer advance per byte
`define LRD_INC_STATIC    6'h08
`define LRD_INC_MUX2      6'h04
`define LRD_INC_MUX3      6'h03
`define LRD_INC_MUX4      6'h02

// blink: half periods in display clock ticks (ratios 768, 1536, 3072)
`define LRD_BLINK_HALF1   12'h180
`define LRD_BLINK_HALF2   12'h300
`define LRD_BLINK_HALF3   12'h600

// reset values
`define LRD_RST_MODE      2'h1
`define LRD_RST_ENABLE    1'b0

`endif

// ---- hdl/lrd_pkg.sv ----
// types of the display RAM command decoder
`include "lrd_cfg.svh"
package lrd_pkg;

   // command parser: one-hot, command bytes or display data bytes
   typedef enum logic [1:0] {
      LRD_PS_CMD  = 2'b01,
      LRD_PS_DATA = 2'b10
   } lrd_parse_t;

   typedef struct packed {
      logic [3:0][31:0] ram;
      logic [4:0]       ptr;
      logic [2:0]       sub_cnt;
      logic [1:0]       mode;
      logic             enable;
      logic             bias;
      logic             in_bank;
      logic             out_bank;
      logic             alternate_bank_blink;
      logic [1:0]       blink_rate_field;
      lrd_parse_t       parse;
      logic [1:0]       scan_row;
      logic [11:0]      blink_cnt;
      logic             blink_phase;
      logic             osc_prev;
      logic [31:0]      seg;
      logic [3:0]       bp;
      logic             dp_wr;
      logic [7:0]       dp_addr;
      logic [31:0]      rdata;
   } lrd_state_t;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] stable;
   } lrd_sync_state_t;

endpackage

// ---- hdl/lrd_sync.sv ----
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module lrd_sync #(
   parameter int WIDTH = 3
) (
   input  wire  logic             mclk,
   input  wire  logic             rst_n,
   input  wire  logic [WIDTH-1:0] async_in,
   output logic       [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] stable;
   } lrd_sync_t;

   lrd_sync_t s_ff;
   lrd_sync_t nxt_s;

   always_comb begin
      nxt_s    = s_ff;
      nxt_s.s1 = async_in;
      nxt_s.s2 = s_ff.s1;
      nxt_s.s3 = s_ff.s2;
      // per bit: a change counts once stages two and three agree
      for (int i = 0; i < WIDTH; i++) begin
         if (s_ff.s2[i] == s_ff.s3[i]) begin
            nxt_s.stable[i] = s_ff.s3[i];
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign sync_out = s_ff.stable;
endmodule
`default_nettype wire

// ---- hdl/lrd_core.sv ----
// command decoder, display RAM write addressing, row scan and blinking
`timescale 1ns/1ps
`default_nettype none
`include "lrd_cfg.svh"
module lrd_core (
   input  wire  logic        mclk,
   input  wire  logic        rst_n,
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic       [31:0] hrdata,
   output logic              hreadyout,
   output logic              hresp,
   input  wire  logic        strap_sub_bit0,
   input  wire  logic        strap_sub_bit1,
   input  wire  logic        strap_sub_bit2,
   input  wire  logic        disp_osc,
   output logic       [31:0] segment_out,
   output logic       [3:0]  backplane_sel
);
   lrd_pkg::lrd_state_t s_ff;
   lrd_pkg::lrd_state_t nxt_s;

   logic [2:0] strap_sync;
   logic [0:0] osc_sync;
   logic       hready_ff;

   logic [7:0]  byte_in;
   logic        byte_vld;
   logic        sub_match;
   logic [5:0]  inc;
   logic [5:0]  ptr_sum;
   logic [5:0]  col;
   logic [1:0]  row;
   logic [2:0]  grp;
   logic [1:0]  bank_ofs;
   logic [1:0]  nrows_m1;
   logic [11:0] half;
   logic        swap_ok;
   logic        show_bank;
   logic [1:0]  show_row;
   logic        blank;
   logic        osc_rise;

   lrd_sync #(
      .WIDTH (3)
   ) u_strap_sync (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .async_in ({strap_sub_bit2, strap_sub_bit1, strap_sub_bit0}),
      .sync_out (strap_sync)
   );

   lrd_sync #(
      .WIDTH (1)
   ) u_osc_sync (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .async_in (disp_osc),
      .sync_out (osc_sync)
   );

   assign byte_in  = hwdata[7:0];
   assign byte_vld = s_ff.dp_wr && (s_ff.dp_addr == `LRD_OFS_XFER);
   assign osc_rise = osc_sync[0] && !s_ff.osc_prev;
   // strap must stay put while addressed; the synchronised copy is used
   assign sub_match = (s_ff.sub_cnt == strap_sync);

   always_comb begin
      unique case (s_ff.mode)
         `LRD_MODE_STATIC: begin
            inc      = `LRD_INC_STATIC;
            nrows_m1 = 2'h0;
            grp      = 3'h1;
         end
         `LRD_MODE_MUX2: begin
            inc      = `LRD_INC_MUX2;
            nrows_m1 = 2'h1;
            grp      = 3'h2;
         end
         `LRD_MODE_MUX3: begin
            inc      = `LRD_INC_MUX3;
            nrows_m1 = 2'h2;
            grp      = 3'h3;
         end
         `LRD_MODE_MUX4: begin
            inc      = `LRD_INC_MUX4;
            nrows_m1 = 2'h3;
            grp      = 3'h4;
         end
      endcase
   end

   always_comb begin
      unique case (s_ff.blink_rate_field)
         2'h1:    half = `LRD_BLINK_HALF1;
         2'h2:    half = `LRD_BLINK_HALF2;
         2'h3:    half = `LRD_BLINK_HALF3;
         2'h0:    half = `LRD_BLINK_HALF1;
      endcase
   end

   // bank pairs only exist in static and 1:2 drive
   assign swap_ok = (s_ff.mode == `LRD_MODE_STATIC) ||
                    (s_ff.mode == `LRD_MODE_MUX2);
   assign bank_ofs = (swap_ok && s_ff.in_bank) ? 2'h2 : 2'h0;
   assign show_bank = s_ff.out_bank ^ (swap_ok && s_ff.alternate_bank_blink
                      && (s_ff.blink_rate_field != 2'h0)
                      && s_ff.blink_phase);
   assign show_row = (swap_ok && show_bank) ? s_ff.scan_row + 2'h2
                                            : s_ff.scan_row;
   // whole display blink only where no bank swap replaces it
   assign blank = !s_ff.enable ||
                  ((s_ff.blink_rate_field != 2'h0) && s_ff.blink_phase &&
                   !(swap_ok && s_ff.alternate_bank_blink));

   always_comb begin
      nxt_s    = s_ff;
      ptr_sum  = {1'b0, s_ff.ptr} + inc;
      col      = 6'h00;
      row      = 2'h0;

      // ---------------- bus slave: capture address phase ----------------
      nxt_s.dp_wr   = 1'b0;
      nxt_s.dp_addr = haddr[7:0];
      if (hsel && htrans[1] && hready) begin
         nxt_s.dp_wr = hwrite;
         if (haddr[31:8] != 24'h000000) begin
            nxt_s.rdata = 32'h0000_0000;
         end else begin
            unique case (haddr[7:0])
               `LRD_OFS_STATUS: begin
                  nxt_s.rdata = 32'h0000_0000;
                  nxt_s.rdata[`LRD_ST_PTR_LSB +: 5]  = s_ff.ptr;
                  nxt_s.rdata[`LRD_ST_SUB_LSB +: 3]  = s_ff.sub_cnt;
                  nxt_s.rdata[`LRD_ST_MODE_LSB +: 2] = s_ff.mode;
                  nxt_s.rdata[`LRD_ST_EN_BIT]        = s_ff.enable;
                  nxt_s.rdata[`LRD_ST_INB_BIT]       = s_ff.in_bank;
                  nxt_s.rdata[`LRD_ST_OUTB_BIT]      = s_ff.out_bank;
                  nxt_s.rdata[`LRD_ST_ALTB_BIT] = s_ff.alternate_bank_blink;
                  nxt_s.rdata[`LRD_ST_RATE_LSB +: 2] = s_ff.blink_rate_field;
                  nxt_s.rdata[`LRD_ST_BIAS_BIT]      = s_ff.bias;
                  nxt_s.rdata[`LRD_ST_DATA_BIT] =
                     (s_ff.parse == lrd_pkg::LRD_PS_DATA);
                  nxt_s.rdata[`LRD_ST_PHASE_BIT]     = s_ff.blink_phase;
                  nxt_s.rdata[`LRD_ST_STRAP_LSB +: 3] = strap_sync;
               end
               `LRD_OFS_RAM_ROW0: nxt_s.rdata = s_ff.ram[0];
               `LRD_OFS_RAM_ROW1: nxt_s.rdata = s_ff.ram[1];
               `LRD_OFS_RAM_ROW2: nxt_s.rdata = s_ff.ram[2];
               `LRD_OFS_RAM_ROW3: nxt_s.rdata = s_ff.ram[3];
               default:           nxt_s.rdata = 32'h0000_0000;
            endcase
         end
      end

      // ---------------- byte stream: commands and display data ----------
      if (byte_vld) begin
         // start flag opens a fresh transfer; its first byte is a command
         if (hwdata[`LRD_XFER_START_BIT] ||
             (s_ff.parse == lrd_pkg::LRD_PS_CMD)) begin
            nxt_s.parse = byte_in[7] ? lrd_pkg::LRD_PS_CMD
                                     : lrd_pkg::LRD_PS_DATA;
            if (byte_in[6:5] == 2'b10) begin
               nxt_s.enable = byte_in[3];
               nxt_s.bias   = byte_in[2];
               nxt_s.mode   = byte_in[1:0];
            end else if (byte_in[6:5] == 2'b00) begin
               nxt_s.ptr = byte_in[4:0];
            end else if (byte_in[6:3] == 4'b1100) begin
               nxt_s.sub_cnt = byte_in[2:0];
            end else if (byte_in[6:2] == 5'b11110) begin
               nxt_s.in_bank  = byte_in[1];
               nxt_s.out_bank = byte_in[0];
            end else if (byte_in[6:3] == 4'b1110) begin
               nxt_s.alternate_bank_blink = byte_in[2];
               nxt_s.blink_rate_field     = byte_in[1:0];
            end
         end else begin
            // bit k of the walk takes byte bit 7-k: rows first, then columns
            for (int k = 0; k < 8; k++) begin
               col = {1'b0, s_ff.ptr} + 6'(k / int'(grp));
               row = 2'(k % int'(grp)) + bank_ofs;
               // in 1:3 the ninth cell of three columns is simply not reached
               if (sub_match && !col[5]) begin
                  nxt_s.ram[row][col[4:0]] = byte_in[7-k];
               end
            end
            nxt_s.ptr = ptr_sum[4:0];
            if (ptr_sum[5]) begin
               nxt_s.sub_cnt = s_ff.sub_cnt + 3'h1;
            end
         end
      end

      // ---------------- display side: row scan and blink timer ----------
      nxt_s.osc_prev = osc_sync[0];
      if (osc_rise) begin
         nxt_s.scan_row = (s_ff.scan_row >= nrows_m1) ? 2'h0
                          : s_ff.scan_row + 2'h1;
         if (s_ff.blink_rate_field == 2'h0) begin
            nxt_s.blink_cnt   = 12'h000;
            nxt_s.blink_phase = 1'b0;
         end else if (s_ff.blink_cnt >= half - 12'h001) begin
            nxt_s.blink_cnt   = 12'h000;
            nxt_s.blink_phase = !s_ff.blink_phase;
         end else begin
            nxt_s.blink_cnt = s_ff.blink_cnt + 12'h001;
         end
      end
      nxt_s.seg = blank ? 32'h0000_0000 : s_ff.ram[show_row];
      nxt_s.bp  = 4'h1 << s_ff.scan_row;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff          <= '0;
         s_ff.mode     <= `LRD_RST_MODE;
         s_ff.enable   <= `LRD_RST_ENABLE;
         s_ff.parse    <= lrd_pkg::LRD_PS_CMD;
         s_ff.bp       <= 4'h1;
         hready_ff     <= 1'b0;
      end else begin
         s_ff          <= nxt_s;
         hready_ff     <= 1'b1;
      end
   end

   assign hrdata        = s_ff.rdata;
   assign hreadyout     = hready_ff;
   assign hresp         = 1'b0;
   assign segment_out   = s_ff.seg;
   assign backplane_sel = s_ff.bp;
endmodule
`default_nettype wire

// ---- tb/lrd_core_assertions.sv ----
// concurrent checks on the ports of the display RAM command decoder
`timescale 1ns/1ps
`default_nettype none
module lrd_core_chk (
   input  wire  logic        mclk,
   input  wire  logic        rst_n,
   input  wire  logic        hsel,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hready,
   input  wire  logic [31:0] hrdata,
   input  wire  logic        hreadyout,
   input  wire  logic        hresp,
   input  wire  logic        disp_osc,
   input  wire  logic [31:0] segment_out,
   input  wire  logic [3:0]  backplane_sel
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response is not okay");
   a_ready_on: assert property ($past(rst_n) |-> hreadyout)
      else $error("slave not ready after reset");
   a_zero_wait: assert property (hsel && htrans[1] && hready |=> hreadyout[*2])
      else $error("wait state inserted");
   a_rdata_hold: assert property
      (!(hsel && htrans[1] && hready) |=> $stable(hrdata))
      else $error("read data moved without a request");
   a_bp_onehot: assert property ($onehot(backplane_sel))
      else $error("row select not one-hot");
   // eight quiet cycles cover the synchroniser and the output register
   a_bp_quiet: assert property
      ((!disp_osc && !htrans[1])[*8] |=> $stable(backplane_sel))
      else $error("row select moved without a display tick");
   a_seg_quiet: assert property
      ((!disp_osc && !htrans[1])[*8] |=> $stable(segment_out))
      else $error("segment data moved without a cause");
   a_ready_hold: assert property (hreadyout |=> hreadyout)
      else $error("ready dropped");
endmodule
`default_nettype wire

// ---- tb/lrd_host_bfm.sv ----
// bus master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module lrd_host_bfm (
   input  wire  logic        mclk,
   output logic              hsel,
   output logic       [31:0] haddr,
   output logic       [1:0]  htrans,
   output logic              hwrite,
   output logic       [2:0]  hsize,
   output logic       [31:0] hwdata,
   input  wire  logic        hready,
   input  wire  logic [31:0] hrdata
);
   int hang = 0;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // waits are bounded so a stuck slave cannot hang the run
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do begin
         @(posedge mclk);
         n++;
      end while (hready !== 1'b1 && n < 16);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (hready !== 1'b1 && n < 32);
      q = hrdata;
      if (n >= 32) hang++;
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the display RAM command decoder
`timescale 1ns/1ps
`default_nettype none
`include "lrd_cfg.svh"
module tb_top;
   typedef struct packed {
      logic [1:0]  mode;
      logic [4:0]  ptr;
      logic [7:0]  dat;
      logic [7:0]  row_ofs;
      logic [31:0] exp_row;
      logic [31:0] exp_st;
   } lrd_row_t;
   logic        mclk = 1'b0;
   logic        rst_n, disp_osc, hsel, hwrite, hreadyout, hresp;
   logic [2:0]  strap, hsize;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, segment_out, q;
   logic [3:0]  backplane_sel;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cnt;
   lrd_row_t    rows [8] = '{
      '{`LRD_MODE_STATIC, 5'h00, 8'hC1, 8'h10, 32'h83, 32'h008},
      '{`LRD_MODE_MUX2, 5'h04, 8'hB4, 8'h10, 32'h30, 32'h008},
      '{`LRD_MODE_MUX2, 5'h04, 8'hB4, 8'h14, 32'h60, 32'h008},
      '{`LRD_MODE_MUX3, 5'h00, 8'hFF, 8'h18, 32'h3, 32'h003},
      '{`LRD_MODE_MUX3, 5'h00, 8'hFF, 8'h1C, 32'h0, 32'h003},
      '{`LRD_MODE_MUX4, 5'h1E, 8'h96, 8'h10, 32'h40000000, 32'h100},
      '{`LRD_MODE_MUX4, 5'h1E, 8'h96, 8'h14, 32'h80000000, 32'h100},
      '{`LRD_MODE_MUX4, 5'h1E, 8'h96, 8'h1C, 32'h40000000, 32'h100}};

   always #12.5 mclk = ~mclk;

   lrd_host_bfm host (.mclk(mclk), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata));
   lrd_core DUT (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .strap_sub_bit0(strap[0]), .strap_sub_bit1(strap[1]),
      .strap_sub_bit2(strap[2]), .disp_osc(disp_osc),
      .segment_out(segment_out), .backplane_sel(backplane_sel));

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic stop_test;
      fail_count += host.hang;
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic rst;
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
   endtask
   // bit 8 opens a new transfer, so the byte is taken as a command
   task automatic b(input logic [8:0] v);
      host.xfer(1'b1, 8'h00, {23'h0, v}, q);
      if (host.hang != 0) stop_test();
   endtask
   task automatic rd(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0, q);
      if (host.hang != 0) stop_test();
   endtask
   task automatic tick(input int k);
      repeat (k) begin
         disp_osc <= 1'b1;
         repeat (5) @(posedge mclk);
         disp_osc <= 1'b0;
         repeat (5) @(posedge mclk);
      end
   endtask
   task automatic till(input logic blank);
      cnt = 0;
      while ((segment_out === 32'h0) !== blank && cnt < 2000) begin
         tick(1);
         cnt++;
      end
      if (cnt >= 2000) begin
         fail_count++;
         stop_test();
      end
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      fail_count++;
      stop_test();
   end
   initial begin
      rst_n = 1'b0;
      strap = 3'h0;
      disp_osc = 1'b0;
      @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         rst();
         b({7'h70, rows[i].mode});
         b({4'h0, rows[i].ptr});
         b({1'b0, rows[i].dat});
         rd(rows[i].row_ofs);
         chk(q, rows[i].exp_row);
         rd(8'h04);
         chk(q & 32'h71F, rows[i].exp_st);
      end
      $display("done: mapping rows");
      rst();
      b(9'h1C3);
      b(9'h000);
      b(9'h0FF);
      b(9'h000);
      rd(8'h10);
      chk(q, 32'h7);
      rd(8'h04);
      chk(q & 32'h71F, 32'h006);
      $display("done: back to back triples");
      rst();
      b(9'h1C1);
      b(9'h0FA);
      b(9'h000);
      b(9'h0C1);
      rd(8'h18);
      chk(q, 32'h83);
      rd(8'h10);
      chk(q, 32'h0);
      rd(8'h40);
      chk(q, 32'h0);
      $display("done: input bank");
      // host rewrites the third column so its row-2 cell is reached
      rst();
      b(9'h1C3);
      b(9'h000);
      b(9'h0FF);
      b(9'h102);
      b(9'h080);
      rd(8'h10);
      chk(q, 32'h7);
      rd(8'h14);
      chk(q, 32'h3);
      $display("done: overlapping rewrite");
      // group blink in 1:4 is done by the host rewriting the RAM
      rst();
      b(9'h1C8);
      b(9'h000);
      b(9'h0F0);
      repeat (2) @(posedge mclk);
      chk(segment_out, 32'h1);
      b(9'h100);
      b(9'h000);
      repeat (2) @(posedge mclk);
      chk(segment_out, 32'h0);
      $display("done: host group blink");
      rst();
      b(9'h1C9);
      b(9'h000);
      b(9'h0C1);
      tick(3);
      chk(segment_out, 32'h83);
      chk({28'h0, backplane_sel}, 32'h1);
      b(9'h141);
      tick(2);
      chk(segment_out, 32'h0);
      b(9'h1C9);
      b(9'h071);
      till(1'b0);
      till(1'b1);
      till(1'b0);
      // half of a 768-tick blink period
      chk(32'(cnt), 32'h180);
      $display("done: enable and blink");
      strap <= 3'h2;
      repeat (5) @(posedge mclk);
      rst();
      b(9'h1C1);
      b(9'h000);
      b(9'h0FF);
      rd(8'h10);
      chk(q, 32'h0);
      rd(8'h04);
      chk(q & 32'h71F, 32'h008);
      b(9'h1E2);
      b(9'h000);
      b(9'h0FF);
      rd(8'h10);
      chk(q, 32'hFF);
      chk({31'h0, hresp}, 32'h0);
      $display("done: subaddress");
      stop_test();
   end
endmodule

bind lrd_core lrd_core_chk u_chk (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
   .htrans(htrans), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .disp_osc(disp_osc),
   .segment_out(segment_out), .backplane_sel(backplane_sel));
`default_nettype wire
